/* File: rtl/rtd_readout.sv */
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - each channel takes twenty filtered samples per scan
// - one status word then four channel words are readable
// - status holds per-channel limit flags and wire-break flags
// - after reset all four channels convert
// - wire break sets the flag and holds the last good value
// - limits and conversion follow config; disabled channels are skipped
// - one switch setting serves all channels
// - switches off: 3-wire, platinum, celsius, raw; on: the others
// - platinum raw spans 0..7500 celsius, 0..13500 fahrenheit; nickel 0..3500, 0..6300
// - scaled words are signed tenths of a degree
// - platinum raw zero at -150 C, ten counts per degree
// - nickel raw zero at -50 C, 3500 at 300 C
// - configuration error blinks the activity indicator slowly
// - 15-bit conversion, ranges clipped per sensor type
// - status bits 0-7 limit pairs, bits 8-11 break flags
// - status bits 13:12 sensor type and wire count, 15:14 zero
// - each limit output on while its low or high flag is set
// - disabled channel keeps its last converted value
module rtd_readout #(
   parameter int BLINK_HALF_CYC = rtd_pkg::BLINK_HALF_CYC
)(
   // clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // apb slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   // configuration switch pins
   input  wire logic                 wire_count_switch,
   input  wire logic                 sensor_type_switch,
   input  wire logic                 temp_scale_switch,
   input  wire logic                 data_format_switch,
   // analog front end
   output logic                      samp_req,
   output logic [1:0]                samp_ch,
   input  wire logic                 samp_valid,
   input  wire rtd_pkg::rtd_sample_t samp,
   // discrete outputs, bit 0 is limit_output_ch1
   output logic [3:0]                limit_output,
   output logic                      activity_indicator
);
   typedef enum logic [1:0] {S_PICK, S_WAIT, S_STORE} rtd_state_t;

   localparam int BL_W = $clog2(BLINK_HALF_CYC);

   function automatic logic below(input logic [15:0] a,
                                  input logic [15:0] b,
                                  input logic        sgn);
      below = sgn ? ($signed(a) < $signed(b)) : (a < b);
   endfunction : below

   logic [3:0]           sw_meta;
   logic [3:0]           sw_sync;
   logic [3:0]           sw_pins;
   rtd_pkg::rtd_switch_t sw;
   logic [15:0]          cfg_ctrl;
   logic [15:0]          cfg_lim [0:7];
   logic [15:0]          chan_word [0:3];
   logic [3:0]           lo_flag;
   logic [3:0]           hi_flag;
   logic [3:0]           brk_flag;
   logic [7:0]           lim_pairs;
   logic [15:0]          status_word;
   rtd_state_t           st;
   rtd_state_t           next_st;
   logic [1:0]           cur_ch;
   logic                 start_filter;
   logic                 filt_done;
   logic [14:0]          filt_avg;
   logic                 filt_brk;
   logic [3:0]           conv_en;
   logic [7:0]           lim_en;
   logic [3:0]           cfg_bad;
   logic                 cfg_err;
   logic [BL_W-1:0]      blink_cnt;
   logic                 blink_tick;

   // switch pins are asynchronous to pclk
   assign sw_pins = {data_format_switch, temp_scale_switch,
                     sensor_type_switch, wire_count_switch};
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sw_meta <= 4'h0;
         sw_sync <= 4'h0;
      end
      else
      begin
         sw_meta <= sw_pins;
         sw_sync <= sw_meta;
      end
   end
   assign sw = rtd_pkg::rtd_switch_t'(sw_sync);

   // apb decode
   logic [9:0]  word_idx;
   logic [9:0]  ch_rel;
   logic [9:0]  cfg_rel;
   logic        is_status;
   logic        is_chan;
   logic        is_cfg;
   logic        legal;
   logic        setup;
   logic        apb_wr;
   logic [15:0] cfg_rd;
   logic [15:0] rd_word;
   logic [2:0]  lim_idx;

   assign word_idx  = paddr[11:2];
   assign ch_rel    = word_idx - rtd_pkg::IDX_CH1;
   assign cfg_rel   = word_idx - rtd_pkg::IDX_CFG;
   assign is_status = word_idx == rtd_pkg::IDX_STATUS;
   assign is_chan   = word_idx >= rtd_pkg::IDX_CH1 && ch_rel < 10'h004;
   assign is_cfg    = word_idx >= rtd_pkg::IDX_CFG
                      && cfg_rel < 10'(rtd_pkg::CFG_WORDS);
   assign legal     = pwrite ? is_cfg : (is_status | is_chan | is_cfg);
   assign setup     = psel & ~penable;
   assign apb_wr    = psel & penable & pready & pwrite & is_cfg;
   assign lim_idx   = 3'(cfg_rel[3:0] - rtd_pkg::CFG_LIM1);
   assign cfg_rd    = (cfg_rel[3:0] == rtd_pkg::CFG_CTRL) ? cfg_ctrl :
                      (cfg_rel[3:0] >= rtd_pkg::CFG_LIM1) ? cfg_lim[lim_idx]
                                                          : 16'h0000;
   assign rd_word   = is_status ? status_word :
                      is_chan   ? chan_word[ch_rel[1:0]] :
                      is_cfg    ? cfg_rd : 16'h0000;

   // one wait-free access phase; data fetched in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup & ~legal;
         if (setup)
            prdata <= (!pwrite && legal) ? {16'h0000, rd_word}
                                         : 32'h0000_0000;
      end
   end

   // configuration memory
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg_ctrl <= rtd_pkg::CTRL_RST;
         for (int i = 0; i < 8; i++)
            cfg_lim[i] <= 16'h0000;
      end
      else if (apb_wr)
      begin
         if (cfg_rel[3:0] == rtd_pkg::CFG_CTRL)
            cfg_ctrl <= pwdata[15:0];
         else if (cfg_rel[3:0] >= rtd_pkg::CFG_LIM1)
            cfg_lim[lim_idx] <= pwdata[15:0];
      end
   end

   assign conv_en = cfg_ctrl[rtd_pkg::CONV_LSB +: 4];
   assign lim_en  = cfg_ctrl[7:0];

   // scan sequencer
   always_comb
   begin
      next_st      = st;
      start_filter = 1'b0;
      case (st)
         S_PICK:
            if (conv_en[cur_ch])
            begin
               start_filter = 1'b1;
               next_st      = S_WAIT;
            end
         S_WAIT:
            if (filt_done)
               next_st = S_STORE;
         S_STORE:
            next_st = S_PICK;
         default:
            next_st = S_PICK;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st     <= S_PICK;
         cur_ch <= 2'b00;
      end
      else
      begin
         st <= next_st;
         if (st == S_STORE || (st == S_PICK && !conv_en[cur_ch]))
            cur_ch <= cur_ch + 2'b01;
      end
   end

   rtd_filter #(
      .SAMPLES (rtd_pkg::NSAMP)
   ) u_filter (
      .clk        (pclk),
      .rst_n      (presetn),
      .start      (start_filter),
      .ch         (cur_ch),
      .done       (filt_done),
      .avg        (filt_avg),
      .brk        (filt_brk),
      .samp_req   (samp_req),
      .samp_ch    (samp_ch),
      .samp_valid (samp_valid),
      .samp       (samp)
   );

   // encoding of the filtered reading
   logic [15:0] span;
   logic [15:0] clamped;
   logic [31:0] f_prod;
   logic [15:0] raw;
   logic [15:0] offset;
   logic [15:0] next_word;

   assign span    = sw.nickel ? rtd_pkg::NI_SPAN : rtd_pkg::PT_SPAN;
   assign clamped = ({1'b0, filt_avg} > span) ? span
                                              : {1'b0, filt_avg};
   // 2^18 / 5 keeps the floor of x * 9 / 5 exact over the whole span
   assign f_prod  = 32'(clamped) * rtd_pkg::F_MUL
                    * 32'(rtd_pkg::DIV_RECIP);
   assign raw     = sw.fahrenheit ? {2'b00, f_prod[31:18]} : clamped;
   assign offset  = sw.nickel
                    ? (sw.fahrenheit ? rtd_pkg::NI_OFS_F : rtd_pkg::NI_OFS_C)
                    : (sw.fahrenheit ? rtd_pkg::PT_OFS_F
                                     : rtd_pkg::PT_OFS_C);
   assign next_word = sw.scaled ? raw - offset : raw;

   // per-channel words and flags
   genvar g;
   generate
      for (g = 0; g < rtd_pkg::NCH; g++)
      begin : g_ch
         logic        store_me;
         logic        skip_me;
         logic [15:0] eval;

         assign store_me = st == S_STORE && cur_ch == 2'(g);
         assign skip_me  = st == S_PICK && cur_ch == 2'(g) && !conv_en[g];
         assign eval     = filt_brk ? chan_word[g] : next_word;
         assign lim_pairs[2*g]   = lo_flag[g];
         assign lim_pairs[2*g+1] = hi_flag[g];
         assign cfg_bad[g] = lim_en[2*g] & lim_en[2*g+1]
                             & below(cfg_lim[2*g+1], cfg_lim[2*g],
                                     sw.scaled);

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               chan_word[g]    <= 16'h0000;
               brk_flag[g]     <= 1'b0;
               lo_flag[g]      <= 1'b0;
               hi_flag[g]      <= 1'b0;
               limit_output[g] <= 1'b0;
            end
            else
            begin
               limit_output[g] <= lo_flag[g] | hi_flag[g];
               if (store_me)
               begin
                  chan_word[g] <= eval;
                  brk_flag[g]  <= filt_brk;
                  lo_flag[g]   <= lim_en[2*g]
                                  & below(eval, cfg_lim[2*g], sw.scaled);
                  hi_flag[g]   <= lim_en[2*g+1]
                                  & below(cfg_lim[2*g+1], eval, sw.scaled);
               end
               else if (skip_me)
               begin
                  brk_flag[g] <= 1'b0;
                  lo_flag[g]  <= 1'b0;
                  hi_flag[g]  <= 1'b0;
               end
            end
         end
      end
   endgenerate

   assign status_word = {2'b00, sw.nickel, sw.four_wire,
                         brk_flag, lim_pairs};

   // slow blink on a contradictory limit pair
   assign cfg_err    = |cfg_bad;
   assign blink_tick = blink_cnt == BL_W'(BLINK_HALF_CYC - 1);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         blink_cnt          <= '0;
         activity_indicator <= 1'b0;
      end
      else
      begin
         blink_cnt <= blink_tick ? '0 : blink_cnt + BL_W'(1);
         if (!cfg_err)
            activity_indicator <= 1'b1;
         else if (blink_tick)
            activity_indicator <= ~activity_indicator;
      end
   end

   // checks
   logic [4:0] req_cnt;
   logic       cfg_written;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         req_cnt     <= 5'h00;
         cfg_written <= 1'b0;
      end
      else
      begin
         if (start_filter)
            req_cnt <= 5'h00;
         else if (samp_req)
            req_cnt <= req_cnt + 5'h01;
         if (apb_wr)
            cfg_written <= 1'b1;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_twenty;
      filt_done |-> req_cnt == 5'(rtd_pkg::NSAMP);
   endproperty
   a_twenty: assert property (p_twenty)
      else $error("scan did not take twenty samples");

   property p_status_read;
      (setup && !pwrite && is_status) |=> prdata[8] == $past(brk_flag[0])
         && prdata[1] == $past(hi_flag[0])
         && prdata[13] == $past(sw.nickel) && prdata[15:14] == 2'b00;
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status word layout wrong");

   property p_chan_read;
      (setup && !pwrite && word_idx == 10'h002)
         |=> prdata[15:0] == $past(chan_word[1]);
   endproperty
   a_chan_read: assert property (p_chan_read)
      else $error("channel word read wrong");

   property p_reset_conv;
      !cfg_written |-> conv_en == 4'hF;
   endproperty
   a_reset_conv: assert property (p_reset_conv)
      else $error("channels not enabled after reset");

   property p_break_hold;
      (st == S_STORE && filt_brk) |=> brk_flag[$past(cur_ch)]
         && chan_word[$past(cur_ch)] == $past(chan_word[cur_ch]);
   endproperty
   a_break_hold: assert property (p_break_hold)
      else $error("break did not hold last value");

   property p_flag_clear;
      (st == S_STORE && !filt_brk) |=> !brk_flag[$past(cur_ch)];
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("break flag not cleared");

   property p_skip;
      (st == S_PICK && !conv_en[cur_ch])
         |-> !start_filter ##1 cur_ch == $past(cur_ch) + 2'b01;
   endproperty
   a_skip: assert property (p_skip)
      else $error("disabled channel not skipped");

   property p_raw_range;
      (st == S_STORE && !sw.scaled && !filt_brk) |-> next_word <=
         (sw.fahrenheit ? rtd_pkg::RAW_MAX_F : rtd_pkg::PT_SPAN);
   endproperty
   a_raw_range: assert property (p_raw_range)
      else $error("raw word out of span");

   property p_scaled_c;
      (st == S_STORE && sw.scaled && !sw.fahrenheit && !sw.nickel)
         |-> $signed(next_word) >= $signed(rtd_pkg::SC_MIN_C)
             && $signed(next_word) <= $signed(rtd_pkg::SC_MAX_C);
   endproperty
   a_scaled_c: assert property (p_scaled_c)
      else $error("scaled celsius word out of range");

   property p_lim_out;
      (lo_flag[0] || hi_flag[0]) |=> limit_output[0];
   endproperty
   a_lim_out: assert property (p_lim_out)
      else $error("limit output not driven");

   property p_disabled_hold;
      (!conv_en[0] && st != S_STORE) |=> $stable(chan_word[0]);
   endproperty
   a_disabled_hold: assert property (p_disabled_hold)
      else $error("disabled channel word changed");

   property p_blink;
      (cfg_err && blink_tick) |=> activity_indicator
         != $past(activity_indicator);
   endproperty
   a_blink: assert property (p_blink)
      else $error("indicator did not toggle");

   c_break: cover property (st == S_STORE && filt_brk);
   c_blink: cover property (cfg_err && blink_tick);
   c_skip: cover property (st == S_PICK && !conv_en[cur_ch]);
   c_scaled_f: cover property (st == S_STORE && sw.scaled && sw.fahrenheit);
endmodule : rtd_readout

`default_nettype wire

/* File: rtl/rtd_pkg.sv */
`default_nettype none

package rtd_pkg;
   localparam int          NCH            = 4;
   localparam int          NSAMP          = 32'h0000_0014;
   localparam int          CODE_W         = 15;
   // 2^20 / 20, rounded up; average = sum * recip >> shift
   localparam int          DIV_RECIP      = 32'h0000_CCCD;
   localparam int          DIV_SHIFT      = 20;
   // word indices; byte address is four times the index
   localparam logic [9:0]  IDX_STATUS     = 10'h000;
   localparam logic [9:0]  IDX_CH1        = 10'h001;
   localparam logic [9:0]  IDX_CFG        = 10'h010;
   localparam logic [3:0]  CFG_WORDS      = 4'hA;
   localparam logic [3:0]  CFG_CTRL       = 4'h1;
   localparam logic [3:0]  CFG_LIM1       = 4'h2;
   localparam logic [15:0] CTRL_RST       = 16'h0F00;
   localparam int          CONV_LSB       = 8;
   // spans and offsets in counts (tenths of a degree)
   localparam logic [15:0] PT_SPAN        = 16'h1D4C;
   localparam logic [15:0] NI_SPAN        = 16'h0DAC;
   localparam logic [15:0] RAW_MAX_F      = 16'h34BC;
   localparam logic [15:0] PT_OFS_C       = 16'h05DC;
   localparam logic [15:0] PT_OFS_F       = 16'h094C;
   localparam logic [15:0] NI_OFS_C       = 16'h01F4;
   localparam logic [15:0] NI_OFS_F       = 16'h0244;
   localparam logic [15:0] SC_MIN_C       = 16'hFA24;
   localparam logic [15:0] SC_MAX_C       = 16'h1770;
   // celsius to fahrenheit span: x * 9 / 5
   localparam logic [31:0] F_MUL          = 32'h0000_0009;
   localparam logic [31:0] F_RECIP        = 32'h0000_3334;
   localparam int          CLK_HZ         = 32'h0131_2D00;
   localparam int          BLINK_HALF_MS  = 32'h0000_01F4;
   localparam int          BLINK_HALF_CYC = CLK_HZ / 32'h0000_03E8
                                            * BLINK_HALF_MS;

   typedef struct packed {
      logic              brk;
      logic [CODE_W-1:0] code;
   } rtd_sample_t;

   typedef struct packed {
      logic scaled;
      logic fahrenheit;
      logic nickel;
      logic four_wire;
   } rtd_switch_t;
endpackage : rtd_pkg

`default_nettype wire

/* File: rtl/rtd_filter.sv */
`timescale 1ns/1ps
`default_nettype none

module rtd_filter #(
   parameter int SAMPLES = rtd_pkg::NSAMP
)(
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // scan control
   input  wire logic                        start,
   input  wire logic [1:0]                  ch,
   output logic                             done,
   output logic [rtd_pkg::CODE_W-1:0]       avg,
   output logic                             brk,
   // front end
   output logic                             samp_req,
   output logic [1:0]                       samp_ch,
   input  wire logic                        samp_valid,
   input  wire rtd_pkg::rtd_sample_t        samp
);
   localparam int SUM_W = rtd_pkg::CODE_W + $clog2(SAMPLES);
   localparam int CNT_W = $clog2(SAMPLES);
   localparam int PRD_W = SUM_W + 16;

   logic             busy;
   logic             waiting;
   logic             brk_acc;
   logic [CNT_W-1:0] cnt;
   logic [SUM_W-1:0] sum;
   logic [SUM_W-1:0] next_sum;
   logic [PRD_W-1:0] prod;
   logic             last;

   assign next_sum = sum + SUM_W'(samp.code);
   assign prod     = PRD_W'(next_sum) * PRD_W'(rtd_pkg::DIV_RECIP);
   assign last     = cnt == CNT_W'(SAMPLES - 1);

   // one request per sample, answer taken only while waiting
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy     <= 1'b0;
         waiting  <= 1'b0;
         brk_acc  <= 1'b0;
         cnt      <= '0;
         sum      <= '0;
         samp_req <= 1'b0;
         samp_ch  <= 2'b00;
         done     <= 1'b0;
         avg      <= '0;
         brk      <= 1'b0;
      end
      else
      begin
         samp_req <= 1'b0;
         done     <= 1'b0;
         if (start)
         begin
            busy    <= 1'b1;
            waiting <= 1'b0;
            brk_acc <= 1'b0;
            cnt     <= '0;
            sum     <= '0;
            samp_ch <= ch;
         end
         else if (busy && !waiting)
         begin
            samp_req <= 1'b1;
            waiting  <= 1'b1;
         end
         else if (busy && samp_valid)
         begin
            sum     <= next_sum;
            brk_acc <= brk_acc | samp.brk;
            cnt     <= cnt + CNT_W'(1);
            waiting <= 1'b0;
            if (last)
            begin
               busy <= 1'b0;
               done <= 1'b1;
               avg  <= prod[rtd_pkg::DIV_SHIFT +: rtd_pkg::CODE_W];
               brk  <= brk_acc | samp.brk;
            end
         end
      end
   end
endmodule : rtd_filter

`default_nettype wire

/* File: sim/rtd_fe_model.sv */
`timescale 1ns/1ps
`default_nettype none

module rtd_fe_model (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // sample handshake
   input  wire logic             samp_req,
   input  wire logic [1:0]       samp_ch,
   output logic                  samp_valid,
   output rtd_pkg::rtd_sample_t  samp,
   // scenario control
   input  wire logic [3:0][14:0] code,
   input  wire logic [3:0]       brk
);
   logic        pend;
   logic        par;
   logic [2:0]  wt;
   logic [1:0]  ch;
   logic [14:0] c;

   assign c = code[ch];

   // answers alternate prompt and slow; the dither cancels over 20 samples
   always @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         pend       <= 1'b0;
         par        <= 1'b0;
         wt         <= 3'h0;
         ch         <= 2'h0;
         samp_valid <= 1'b0;
         samp       <= '0;
      end
      else
      begin
         samp_valid <= 1'b0;
         if (samp_valid)
            samp <= ~samp;
         if (samp_req)
         begin
            pend <= 1'b1;
            wt   <= par ? 3'h4 : 3'h1;
            ch   <= samp_ch;
         end
         else if (pend && wt != 3'h0)
            wt <= wt - 3'h1;
         else if (pend)
         begin
            pend       <= 1'b0;
            samp_valid <= 1'b1;
            samp.brk   <= brk[ch];
            samp.code  <= (c < 15'h0002) ? c :
                          (par ? c + 15'h0002 : c - 15'h0002);
            par        <= ~par;
         end
      end
endmodule : rtd_fe_model

`default_nettype wire

/* File: sim/rtd_readout_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module rtd_readout_bench;
   logic                 pclk;
   logic                 presetn;
   logic                 psel;
   logic                 penable;
   logic                 pwrite;
   logic [11:0]          paddr;
   logic [31:0]          pwdata;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   rtd_pkg::rtd_switch_t sw;
   logic                 samp_req;
   logic [1:0]           samp_ch;
   logic                 samp_valid;
   rtd_pkg::rtd_sample_t samp;
   logic [3:0]           limit_output;
   logic                 activity_indicator;
   logic [3:0][14:0]     code;
   logic [3:0]           brk;
   logic [31:0]          q;
   logic                 e;
   logic                 last;
   int                   mismatches;
   int                   total_checks;
   int                   i;
   int                   m;
   int                   n;

   rtd_readout #(.BLINK_HALF_CYC(8)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .wire_count_switch(sw.four_wire), .sensor_type_switch(sw.nickel),
      .temp_scale_switch(sw.fahrenheit), .data_format_switch(sw.scaled),
      .samp_req(samp_req), .samp_ch(samp_ch), .samp_valid(samp_valid),
      .samp(samp), .limit_output(limit_output),
      .activity_indicator(activity_indicator));

   rtd_fe_model u_fe (
      .pclk(pclk), .presetn(presetn), .samp_req(samp_req),
      .samp_ch(samp_ch), .samp_valid(samp_valid), .samp(samp),
      .code(code), .brk(brk));

   always #25 pclk = ~pclk;

   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test

   task check(input string nm, input logic [31:0] seen,
              input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task apb(input logic wr, input logic [9:0] idx, input logic [31:0] d,
            output logic [31:0] rq, output logic re);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 16 && pready !== 1'b1; k++)
         @(posedge pclk);
      if (k == 16)
      begin
         mismatches++;
         finish_test();
      end
      rq = prdata;
      re = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wait_reqs(input int cnt);
      int k;
      int c;
      c = 0;
      for (k = 0; k < 20 * cnt && c < cnt; k++)
      begin
         @(posedge pclk);
         if (samp_req === 1'b1)
            c++;
      end
      if (c < cnt)
      begin
         mismatches++;
         finish_test();
      end
   endtask : wait_reqs

   function automatic logic [15:0] expw(input logic [14:0] c);
      logic [31:0] v;
      v = sw.nickel ? rtd_pkg::NI_SPAN : rtd_pkg::PT_SPAN;
      if (c < v)
         v = {17'h0_0000, c};
      if (sw.fahrenheit)
         v = v * rtd_pkg::F_MUL / 5;
      if (sw.scaled)
         v = v - (sw.nickel ?
             (sw.fahrenheit ? rtd_pkg::NI_OFS_F : rtd_pkg::NI_OFS_C) :
             (sw.fahrenheit ? rtd_pkg::PT_OFS_F : rtd_pkg::PT_OFS_C));
      return v[15:0];
   endfunction : expw

   task chk_ch(input int c, input logic [14:0] v);
      apb(1'b0, rtd_pkg::IDX_CH1 + c[9:0], 32'h0000_0000, q, e);
      check("channel", q, {16'h0000, expw(v)});
   endtask : chk_ch

   task chk_st(input logic [15:0] v);
      apb(1'b0, rtd_pkg::IDX_STATUS, 32'h0000_0000, q, e);
      check("status", q, {16'h0000, v});
   endtask : chk_st

   task wcfg(input logic [3:0] w, input logic [15:0] v);
      apb(1'b1, rtd_pkg::IDX_CFG + {6'h00, w}, {16'h0000, v}, q, e);
   endtask : wcfg

   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      sw = '0;
      brk = 4'h0;
      code = {15'h0000, 15'h0FA0, 15'h1F40, 15'h03E8};
      mismatches = 0;
      total_checks = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, rtd_pkg::IDX_CFG + 10'h001, 32'h0000_0000, q, e);
      check("control", q, 32'h0000_0F00);
      for (m = 0; m < 16; m++)
      begin
         sw <= m[3:0];
         wait_reqs(170);
         chk_st({2'b00, sw.nickel, sw.four_wire, 12'h000});
         for (i = 0; i < 4; i++)
            chk_ch(i, code[i]);
      end
      $display("test formats done");
      // scaled format, as the host prefers signed words
      sw <= 4'h8;
      wcfg(4'h2, 16'h0000);
      wcfg(4'h3, 16'h0064);
      wcfg(4'h4, 16'hFC18);
      wcfg(4'h5, 16'h03E8);
      wcfg(4'h1, 16'h0F0F);
      wait_reqs(170);
      chk_st(16'h0009);
      check("limit_output", {28'h000_0000, limit_output}, 32'h3);
      code[1:0] <= {15'h0640, 15'h0640};
      wait_reqs(170);
      chk_st(16'h0000);
      check("limit_output", {28'h000_0000, limit_output}, 32'h0);
      $display("test limits done");
      brk <= 4'h2;
      code[1] <= 15'h1388;
      wait_reqs(170);
      chk_st(16'h0200);
      chk_ch(1, 15'h0640);
      brk <= 4'h0;
      wait_reqs(170);
      // channel 2 now reads 3500, above its high limit of 1000
      chk_st(16'h0008);
      chk_ch(1, 15'h1388);
      $display("test break done");
      wcfg(4'h1, 16'h0B00);
      // let a channel 3 scan already under way finish on the old code
      wait_reqs(21);
      code[2] <= 15'h0640;
      wait_reqs(130);
      chk_ch(2, 15'h0FA0);
      wcfg(4'h1, 16'h0F00);
      $display("test disable done");
      wcfg(4'h2, 16'h0064);
      wcfg(4'h3, 16'h0032);
      wcfg(4'h1, 16'h0F03);
      n = 0;
      last = activity_indicator;
      repeat (40)
      begin
         @(posedge pclk);
         if (activity_indicator !== last)
            n++;
         last = activity_indicator;
      end
      check("blink", {31'h0000_0000, n >= 4}, 32'h1);
      wcfg(4'h1, 16'h0F00);
      repeat (20) @(posedge pclk);
      check("steady", {31'h0000_0000, activity_indicator}, 32'h1);
      $display("test blink done");
      apb(1'b0, 10'h005, 32'h0000_0000, q, e);
      check("unmapped", {q[31:1], e}, 32'h1);
      apb(1'b1, rtd_pkg::IDX_CH1, 32'h0000_1234, q, e);
      check("ro_err", {31'h0000_0000, e}, 32'h1);
      chk_ch(0, 15'h0640);
      $display("test map done");
      finish_test();
   end
endmodule : rtd_readout_bench

`default_nettype wire
